// ### design/sysid_pkg.sv
// constants, field layouts and encodings of the identification register bank
package sysid_pkg;

    localparam int WORD_W = 32;
    localparam int CRN_W = 4;
    localparam int OP1_W = 3;
    localparam int CRM_W = 4;
    localparam int OP2_W = 3;

    // encodings of the identification group
    localparam logic [3:0] CRN_ID = 4'h0;
    localparam logic [2:0] OP1_ID = 3'h0;
    localparam logic [3:0] CRM_ID = 4'h0;
    localparam logic [2:0] SEL_MAIN = 3'h0;
    localparam logic [2:0] SEL_CACHE = 3'h1;
    localparam logic [2:0] SEL_TCM = 3'h2;
    localparam logic [2:0] SEL_MPU = 3'h4;
    localparam logic [2:0] SEL_MPID = 3'h5;

    // encoding of the whole data cache invalidate operation
    localparam logic [3:0] CRN_IMPL = 4'hf;
    localparam logic [2:0] OP1_IMPL = 3'h0;
    localparam logic [3:0] CRM_INVAL = 4'h5;
    localparam logic [2:0] OP2_INVAL = 3'h0;

    // main identification word layout
    localparam int MAKER_LSB = 24;
    localparam int MAKER_W = 8;
    localparam int MAJOR_LSB = 20;
    localparam int REV_W = 4;
    localparam int ARCH_LSB = 16;
    localparam int ARCH_W = 4;
    localparam logic [3:0] ARCH_FEATURE = 4'hf;
    localparam int PART_LSB = 4;
    localparam int PART_W = 12;
    localparam int MINOR_LSB = 0;

    // cache geometry word layout
    localparam int CT_TOP_LSB = 28;
    localparam logic [3:0] CT_TOP = 4'h8;
    localparam int WB_GRANULE_LSB = 24;
    localparam int EXCL_GRANULE_LSB = 20;
    localparam logic [3:0] GRANULE_NONE = 4'h0;
    localparam int DLINE_LSB = 16;
    localparam int CT_ONES_LSB = 14;
    localparam logic [1:0] CT_ONES = 2'h3;
    localparam int ILINE_LSB = 0;
    localparam logic [3:0] LINE_LOG2 = 4'h3;
    localparam int NIBBLE_W = 4;

    // coupled memory count word layout
    localparam int SECOND_MEM_LSB = 16;
    localparam int FIRST_MEM_LSB = 0;
    localparam int MEM_COUNT_W = 3;
    localparam logic [2:0] MEM_COUNT_ONE = 3'h1;

    // both coupled memories reachable from instruction and data sides
    localparam logic [3:0] SIDE_EN_RESET = 4'hf;

    typedef enum logic [0:0] {
        SYSID_ST_IDLE = 1'b0,
        SYSID_ST_ANSWER = 1'b1
    } sysid_state_t;

endpackage

// ### design/sysid_sel_if.sv
// selector and word exchanged between the bank and its word composer
`timescale 1ns/1ps
interface sysid_sel_if;
    logic [2:0] selector;
    logic [31:0] word;

    modport requester (
        output selector,
        input word
    );

    modport rom (
        input selector,
        output word
    );
endinterface

// ### design/sysid_word_rom.sv
// composes the constant identification words from the selector
`timescale 1ns/1ps
module sysid_word_rom #(
    parameter logic [7:0] MAKER_CODE = 8'h5a,
    parameter logic [11:0] PART_CODE = 12'h7e1,
    parameter logic [3:0] MAJOR_REV = 4'h0,
    parameter logic [3:0] MINOR_REV = 4'h0
) (
    sysid_sel_if.rom sel
);
    import sysid_pkg::*;

    logic [31:0] main_word;
    logic [31:0] cache_word;
    logic [31:0] tcm_word;

    always_comb begin
        main_word = '0;
        main_word[MAKER_LSB +: MAKER_W] = MAKER_CODE;
        main_word[MAJOR_LSB +: REV_W] = MAJOR_REV;
        main_word[ARCH_LSB +: ARCH_W] = ARCH_FEATURE;
        main_word[PART_LSB +: PART_W] = PART_CODE;
        main_word[MINOR_LSB +: REV_W] = MINOR_REV;
    end

    always_comb begin
        // bits 13..4 stay zero from the default
        cache_word = '0;
        cache_word[CT_TOP_LSB +: NIBBLE_W] = CT_TOP;
        cache_word[WB_GRANULE_LSB +: NIBBLE_W] = GRANULE_NONE;
        cache_word[EXCL_GRANULE_LSB +: NIBBLE_W] = GRANULE_NONE;
        cache_word[DLINE_LSB +: NIBBLE_W] = LINE_LOG2;
        cache_word[CT_ONES_LSB +: 2] = CT_ONES;
        cache_word[ILINE_LSB +: NIBBLE_W] = LINE_LOG2;
    end

    always_comb begin
        tcm_word = '0;
        tcm_word[SECOND_MEM_LSB +: MEM_COUNT_W] = MEM_COUNT_ONE;
        tcm_word[FIRST_MEM_LSB +: MEM_COUNT_W] = MEM_COUNT_ONE;
    end

    always_comb begin
        case (sel.selector)
            SEL_CACHE: sel.word = cache_word;
            SEL_TCM: sel.word = tcm_word;
            // main word also covers every reserved selector
            default: sel.word = main_word;
        endcase
    end
endmodule // sysid_word_rom

// ### design/sysid_register_bank.sv
// identification register bank of the system control coprocessor
`timescale 1ns/1ps
// What this block does
// - id words read-only, privileged reads only
// - fixed maker and part codes in main word
// - major revision in bits 23..20
// - architecture field all ones
// - minor revision in bits 3..0
// - reserved id selectors return main word
// - selectors 0,1,2 with both fields zero
// - both granule fields read zero
// - data line size log2, value three
// - instruction line size log2, value three
// - cache word fixed top and middle bits
// - memory word top and reserved bits zero
// - one second coupled memory reported
// - one first coupled memory reported
// - both memories reachable from both sides
// - write-only whole data cache invalidate
module sysid_register_bank #(
    parameter int MAKER_CODE = 'h5a, // arbitrary value
    parameter int PART_CODE = 'h7e1, // arbitrary value
    parameter int MAJOR_REV = 0,
    parameter int MINOR_REV = 0
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_privileged_in,
    input wire logic [sysid_pkg::CRN_W-1:0] req_primary_register_field_in,
    input wire logic [sysid_pkg::OP1_W-1:0] req_op1_in,
    input wire logic [sysid_pkg::CRM_W-1:0] req_secondary_register_field_in,
    input wire logic [sysid_pkg::OP2_W-1:0] req_op2_in,
    output logic req_ready_out,
    output logic resp_valid_out,
    output logic [sysid_pkg::WORD_W-1:0] resp_rdata_out,
    output logic resp_undef_out,
    output logic resp_not_claimed_out,
    output logic dcache_invalidate_out,
    output logic first_coupled_memory_instr_en_out,
    output logic first_coupled_memory_data_en_out,
    output logic second_coupled_memory_instr_en_out,
    output logic second_coupled_memory_data_en_out
);
    import sysid_pkg::*;

    generate
        if (MAKER_CODE < 0 || MAKER_CODE > 'hff) begin : g_bad_maker
            $error("maker code must fit eight bits");
        end
        if (PART_CODE < 0 || PART_CODE > 'hfff) begin : g_bad_part
            $error("part code must fit twelve bits");
        end
        if (MAJOR_REV < 0 || MAJOR_REV > 15 || MINOR_REV < 0 || MINOR_REV > 15) begin : g_bad_rev
            $error("revision numbers must fit four bits");
        end
    endgenerate

    sysid_sel_if sel ();

    sysid_word_rom #(
        .MAKER_CODE(MAKER_CODE[7:0]),
        .PART_CODE(PART_CODE[11:0]),
        .MAJOR_REV(MAJOR_REV[3:0]),
        .MINOR_REV(MINOR_REV[3:0])
    ) u_word_rom (
        .sel(sel.rom)
    );

    // the composer is a pure lookup, so the selector goes straight in
    assign sel.selector = req_op2_in;

    sysid_state_t state_reg;
    sysid_state_t state_next;
    logic resp_valid_reg;
    logic resp_valid_next;
    logic [31:0] resp_rdata_reg;
    logic [31:0] resp_rdata_next;
    logic resp_undef_reg;
    logic resp_undef_next;
    logic not_claimed_reg;
    logic not_claimed_next;
    logic inval_reg;
    logic inval_next;
    logic [3:0] side_en_reg;
    logic [3:0] side_en_next;

    logic take;
    logic id_group;
    logic id_foreign_sel;
    logic inval_op;
    logic claimed;

    always_comb begin
        take = (state_reg == SYSID_ST_IDLE) && req_valid_in;
        id_group = (req_primary_register_field_in == CRN_ID) && (req_op1_in == OP1_ID)
            && (req_secondary_register_field_in == CRM_ID);
        // protection type and multiprocessor id live in another bank
        id_foreign_sel = (req_op2_in == SEL_MPU) || (req_op2_in == SEL_MPID);
        inval_op = (req_primary_register_field_in == CRN_IMPL) && (req_op1_in == OP1_IMPL)
            && (req_secondary_register_field_in == CRM_INVAL) && (req_op2_in == OP2_INVAL);
        claimed = (id_group && !id_foreign_sel) || inval_op;
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SYSID_ST_IDLE: begin
                if (take) begin
                    state_next = SYSID_ST_ANSWER;
                end
            end
            SYSID_ST_ANSWER: begin
                state_next = SYSID_ST_IDLE;
            end
            default: begin
                state_next = SYSID_ST_IDLE;
            end
        endcase
    end

    always_comb begin
        resp_valid_next = take;
        resp_rdata_next = '0;
        resp_undef_next = 1'b0;
        not_claimed_next = 1'b0;
        inval_next = 1'b0;
        if (take) begin
            if (!claimed) begin
                not_claimed_next = 1'b1;
            end else if (!req_privileged_in) begin
                // user mode sees nothing of this bank
                resp_undef_next = 1'b1;
            end else if (id_group) begin
                if (req_write_in) begin
                    // read-only: nothing stored, the access faults
                    resp_undef_next = 1'b1;
                end else begin
                    resp_rdata_next = sel.word;
                end
            end else begin
                if (req_write_in) begin
                    inval_next = 1'b1;
                end else begin
                    resp_undef_next = 1'b1;
                end
            end
        end
    end

    always_comb begin
        side_en_next = SIDE_EN_RESET;
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state_reg <= SYSID_ST_IDLE;
            resp_valid_reg <= 1'b0;
            resp_rdata_reg <= '0;
            resp_undef_reg <= 1'b0;
            not_claimed_reg <= 1'b0;
            inval_reg <= 1'b0;
            side_en_reg <= SIDE_EN_RESET;
        end else begin
            state_reg <= state_next;
            resp_valid_reg <= resp_valid_next;
            resp_rdata_reg <= resp_rdata_next;
            resp_undef_reg <= resp_undef_next;
            not_claimed_reg <= not_claimed_next;
            inval_reg <= inval_next;
            side_en_reg <= side_en_next;
        end
    end

    // ready is the registered idle state, low during the answer cycle
    assign req_ready_out = (state_reg == SYSID_ST_IDLE);
    assign resp_valid_out = resp_valid_reg;
    assign resp_rdata_out = resp_rdata_reg;
    assign resp_undef_out = resp_undef_reg;
    assign resp_not_claimed_out = not_claimed_reg;
    assign dcache_invalidate_out = inval_reg;
    assign first_coupled_memory_instr_en_out = side_en_reg[0];
    assign first_coupled_memory_data_en_out = side_en_reg[1];
    assign second_coupled_memory_instr_en_out = side_en_reg[2];
    assign second_coupled_memory_data_en_out = side_en_reg[3];

endmodule // sysid_register_bank

// ### verification/sysid_register_bank_asserts.sv
// concurrent checks on the identification bank ports
`timescale 1ns/1ps
module sysid_register_bank_asserts #(
    parameter int MAKER_CODE = 'h5a,
    parameter int PART_CODE = 'h7e1,
    parameter int MAJOR_REV = 0,
    parameter int MINOR_REV = 0
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_privileged_in,
    input wire logic [sysid_pkg::CRN_W-1:0] req_primary_register_field_in,
    input wire logic [sysid_pkg::OP1_W-1:0] req_op1_in,
    input wire logic [sysid_pkg::CRM_W-1:0] req_secondary_register_field_in,
    input wire logic [sysid_pkg::OP2_W-1:0] req_op2_in,
    input wire logic req_ready_out,
    input wire logic resp_valid_out,
    input wire logic [sysid_pkg::WORD_W-1:0] resp_rdata_out,
    input wire logic resp_undef_out,
    input wire logic resp_not_claimed_out,
    input wire logic dcache_invalidate_out,
    input wire logic first_coupled_memory_instr_en_out,
    input wire logic first_coupled_memory_data_en_out,
    input wire logic second_coupled_memory_instr_en_out,
    input wire logic second_coupled_memory_data_en_out
);
    import sysid_pkg::*;
    localparam logic [31:0] MAIN = {MAKER_CODE[7:0], MAJOR_REV[3:0], 4'hf, PART_CODE[11:0], MINOR_REV[3:0]};
    logic id_grp;
    logic claimed;
    logic inval_op;
    assign id_grp = req_primary_register_field_in == CRN_ID && req_op1_in == OP1_ID
        && req_secondary_register_field_in == CRM_ID;
    assign claimed = id_grp && req_op2_in != SEL_MPU && req_op2_in != SEL_MPID;
    assign inval_op = req_primary_register_field_in == CRN_IMPL && req_op1_in == OP1_IMPL
        && req_secondary_register_field_in == CRM_INVAL && req_op2_in == OP2_INVAL;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_taken;
        req_valid_in && req_ready_out;
    endsequence
    sequence s_id_read;
        s_taken ##0 (claimed && req_privileged_in && !req_write_in);
    endsequence
    a_answer_next_cycle: assert property (s_taken |=> resp_valid_out && !req_ready_out)
        else $error("answer not one cycle after take");
    a_answer_single: assert property (resp_valid_out |=> !resp_valid_out && req_ready_out)
        else $error("answer longer than one cycle");
    a_main_word: assert property (s_id_read ##0 (req_op2_in != SEL_CACHE && req_op2_in != SEL_TCM)
        |=> resp_rdata_out == MAIN && !resp_undef_out)
        else $error("main word wrong");
    a_cache_word: assert property (s_id_read ##0 req_op2_in == SEL_CACHE |=> resp_rdata_out == 32'h8003c003)
        else $error("cache word wrong");
    a_memory_word: assert property (s_id_read ##0 req_op2_in == SEL_TCM |=> resp_rdata_out == 32'h00010001)
        else $error("memory count word wrong");
    a_user_refused: assert property (s_taken ##0 (claimed && !req_privileged_in)
        |=> resp_undef_out && resp_rdata_out == 32'h0)
        else $error("user access not refused");
    a_write_refused: assert property (s_taken ##0 (claimed && req_write_in) |=> resp_undef_out && !dcache_invalidate_out)
        else $error("write to id word not refused");
    a_inval_pulse: assert property (s_taken ##0 (inval_op && req_write_in && req_privileged_in)
        |=> dcache_invalidate_out && !resp_undef_out ##1 !dcache_invalidate_out)
        else $error("invalidate pulse wrong");
    a_memory_sides: assert property (first_coupled_memory_instr_en_out && first_coupled_memory_data_en_out
        && second_coupled_memory_instr_en_out && second_coupled_memory_data_en_out)
        else $error("coupled memory side disabled");
endmodule // sysid_register_bank_asserts

bind sysid_register_bank sysid_register_bank_asserts #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE),
    .MAJOR_REV(MAJOR_REV), .MINOR_REV(MINOR_REV)) u_asserts (.*);

// ### verification/sysid_core_model.sv
// core pipeline model issuing coprocessor register accesses
`timescale 1ns/1ps
module sysid_core_model (
    input wire logic clk_in,
    input wire logic ready_in,
    output logic valid_out,
    output logic [15:0] fields_out
);
    initial begin
        valid_out = 1'b0;
        fields_out = 16'h0;
    end
    // released fields are inverted so a stale sample never looks valid
    task automatic issue(input logic [15:0] f);
        int n;
        @(posedge clk_in);
        valid_out <= 1'b1;
        fields_out <= f;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (!ready_in && n < 20);
        valid_out <= 1'b0;
        fields_out <= ~f;
    endtask
endmodule // sysid_core_model

// ### verification/sysid_register_bank_tb.sv
// self-checking bench for the identification register bank
`timescale 1ns/1ps
module sysid_register_bank_tb;
    import sysid_pkg::*;
    localparam int MAKER = 'h3c; // arbitrary value
    localparam int PART = 'h9d2; // arbitrary value
    localparam logic [31:0] MAIN = {MAKER[7:0], 4'h2, 4'hf, PART[11:0], 4'h5};
    logic sys_clk_in, sys_rst_in, req_valid_in, req_write_in, req_privileged_in;
    logic [3:0] req_primary_register_field_in, req_secondary_register_field_in;
    logic [2:0] req_op1_in, req_op2_in;
    logic req_ready_out, resp_valid_out, resp_undef_out, resp_not_claimed_out, dcache_invalidate_out;
    logic [31:0] resp_rdata_out;
    logic first_coupled_memory_instr_en_out, first_coupled_memory_data_en_out;
    logic second_coupled_memory_instr_en_out, second_coupled_memory_data_en_out;
    int bad_count, num_checks, seed, i;
    logic [31:0] r;
    sysid_register_bank #(.MAKER_CODE(MAKER), .PART_CODE(PART), .MAJOR_REV(2), .MINOR_REV(5)) dut (.*);
    sysid_core_model core (
        .clk_in(sys_clk_in),
        .ready_in(req_ready_out),
        .valid_out(req_valid_in),
        .fields_out({req_write_in, req_privileged_in, req_primary_register_field_in,
            req_secondary_register_field_in, req_op1_in, req_op2_in})
    );
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    task automatic check(input string n, input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // unclaimed encodings win over the privilege check
    function automatic logic [35:0] exp_resp(input logic [15:0] f);
        logic id, op;
        id = f[13:10] == 4'h0 && f[9:6] == 4'h0 && f[5:3] == 3'h0;
        op = f[13:10] == 4'hf && f[9:6] == 4'h5 && f[5:3] == 3'h0 && f[2:0] == 3'h0;
        if ((id && (f[2:0] == 3'h4 || f[2:0] == 3'h5)) || (!id && !op)) return {4'ha, 32'h0};
        if (!f[14] || (id && f[15]) || (op && !f[15])) return {4'hc, 32'h0};
        if (op) return {4'h9, 32'h0};
        case (f[2:0])
            3'h1: return {4'h8, 32'h8003c003};
            3'h2: return {4'h8, 32'h00010001};
            default: return {4'h8, MAIN};
        endcase
    endfunction
    task automatic run(input logic [15:0] f);
        core.issue(f);
        #1;
        check("response", {resp_valid_out, resp_undef_out, resp_not_claimed_out, dcache_invalidate_out,
            resp_rdata_out}, exp_resp(f));
        check("memory sides", {32'h0, first_coupled_memory_instr_en_out, first_coupled_memory_data_en_out,
            second_coupled_memory_instr_en_out, second_coupled_memory_data_en_out}, 36'hf);
    endtask
    task automatic results();
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        seed = 32'hf04a;
        bad_count = 0;
        num_checks = 0;
        sys_rst_in = 1'b1;
        repeat (5) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        // every id selector: user and privileged, reads before writes
        for (i = 0; i < 32; i++) run({i[3], i[4], 11'h0, i[2:0]});
        run({2'b11, 4'hf, 4'h5, 6'h0});
        run({2'b01, 4'hf, 4'h5, 6'h0});
        run({2'b10, 4'hf, 4'h5, 6'h0});
        for (i = 0; i < 80; i++) begin
            r = $random(seed);
            run({r[0], r[1] | r[2], r[3] ? 4'h0 : (r[4] ? 4'hf : r[11:8]),
                r[5] ? 4'h0 : (r[6] ? 4'h5 : r[15:12]), r[7] ? 3'h0 : r[18:16], r[21:19]});
        end
        results();
    end
    initial begin
        repeat (3000) @(posedge sys_clk_in);
        bad_count++;
        results();
    end
endmodule // sysid_register_bank_tb
